/* File: rtl/ets_defines.vh */
/*
  Register map, field positions, reset values and timing constants of the
  exposure trigger sequencer. Assumes inclusion by bare name from rtl/.
*/
`ifndef ETS_DEFINES_VH
`define ETS_DEFINES_VH

// ****************************************
// Register offsets (word addresses)
// ****************************************
`define ETS_ADDR_CTRL     4'h0
`define ETS_ADDR_FRAMES   4'h1
`define ETS_ADDR_EXPOSE   4'h2
`define ETS_ADDR_INTERVAL 4'h3
`define ETS_ADDR_READOUT  4'h4
`define ETS_ADDR_STATUS   4'h5
`define ETS_ADDR_COUNT    4'h6

// ****************************************
// Control fields
// ****************************************
`define ETS_CTRL_SRC_LO   0
`define ETS_CTRL_SRC_HI   1
`define ETS_CTRL_EDGE     2
`define ETS_CTRL_ARM      3
`define ETS_CTRL_CAPTURE  4
`define ETS_CTRL_HALT     5

// Trigger source encodings
`define ETS_SRC_NONE      2'b00
`define ETS_SRC_STANDARD  2'b01
`define ETS_SRC_PULSE     2'b10

// ****************************************
// Reset values
// ****************************************
`define ETS_RST_FRAMES    16'h0001
`define ETS_RST_EXPOSE    32'h0000_0019
`define ETS_RST_INTERVAL  32'h0000_0064
`define ETS_RST_READOUT   32'h0000_0032

`endif

/* File: rtl/ets_count_timer.v */
/*
  Loadable down counter with a one-cycle done pulse.
  Assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/10ps

module ets_count_timer #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Control
  input wire load,
  input wire [WIDTH-1:0] loadValue,
  input wire abort,
  // Status
  output wire busy,
  output reg done
);

  reg [WIDTH-1:0] count_reg;
  reg run_reg;

  assign busy = run_reg;

  // Counts down from the loaded value; zero load finishes after one cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= {WIDTH{1'b0}};
      run_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        run_reg <= 1'b0;
      end else if (load) begin
        count_reg <= loadValue;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          run_reg <= 1'b0;
          done <= 1'b1;
        end else begin
          count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // ets_count_timer

/* File: rtl/ets_exposure_sequencer.v */
/*
  Exposure trigger sequencer: streaming, single-shot and pulse-width modes,
  plus software capture, behind a plain register port.
  Assumes trigger input synchronous-capable via the local two-flop stage,
  one 25 MHz clock and an active-low asynchronous reset.
*/
// What this block does
// - Streaming: active trigger edge starts programmed exposure, then readout.
// - Streaming: cycle then repeats on its own at the frame interval.
// - Streaming: further trigger edges ignored until host halts.
// - Single-shot: each active edge while armed starts one preset exposure then readout.
// - Single-shot: edges during readout are ignored.
// - Single-shot: after readout, return to armed and wait for a new active edge.
// - Pulse-width: exposure spans trigger active level; source sets width.
// - Pulse-width: trigger transitions during readout are ignored.
// - Exposure indicator is high during every exposure, low otherwise.
// - Source none: capture command acquires frames-per-event frames, or one frame when frames is zero.
// - Standard source with frames zero or above one selects streaming.
// - Standard source with frames exactly one selects single-shot.
// - Pulse-width source selects pulse-width mode regardless of frames.
// - Edge select picks rising or falling active edge in streaming, single-shot and pulse-width modes.
// - Readout settings change only readout length, not trigger behaviour.
`timescale 1ns/10ps
`include "ets_defines.vh"

module ets_exposure_sequencer #(
  parameter TIME_WIDTH = 32,
  parameter FRAME_WIDTH = 16
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Register port
  input wire [3:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdData,
  // External trigger and equipment
  input wire triggerIn,
  output reg exposureActive,
  output reg readoutActive,
  output reg frameDone
);

  // ****************************************
  // States
  // ****************************************
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_ARMED = 5'b00010;
  localparam [4:0] ST_EXPOSE = 5'b00100;
  localparam [4:0] ST_READ = 5'b01000;
  localparam [4:0] ST_WAIT = 5'b10000;

  // Mode codes
  localparam [1:0] MODE_STREAM = 2'd0;
  localparam [1:0] MODE_SINGLE = 2'd1;
  localparam [1:0] MODE_PULSE = 2'd2;
  localparam [1:0] MODE_SOFT = 2'd3;

  // ****************************************
  // Registers
  // ****************************************
  reg [1:0] triggerSourceSelect_reg;
  reg triggerEdgeSelect_reg;
  reg [FRAME_WIDTH-1:0] frames_reg;
  reg [TIME_WIDTH-1:0] expose_reg;
  reg [TIME_WIDTH-1:0] interval_reg;
  reg [TIME_WIDTH-1:0] readout_reg;
  reg [4:0] state_reg;
  reg [1:0] mode_reg;
  reg [FRAME_WIDTH-1:0] frameCount_reg;
  reg [TIME_WIDTH-1:0] intervalCount_reg;
  reg syncA_reg;
  reg syncB_reg;
  reg trigPrev_reg;

  wire armCmd;
  wire captureCmd;
  wire haltCmd;
  wire trigActive;
  wire trigPrevActive;
  wire trigStart;
  wire trigStop;
  wire [1:0] modeSel;
  wire expTimerDone;
  wire readTimerDone;
  reg expLoad;
  reg readLoad;
  wire abortAll;

  // Decodes the operating mode from source and frames-per-event
  function [1:0] ets_mode;
    input [1:0] src;
    input [FRAME_WIDTH-1:0] frames;
    begin
      if (src == `ETS_SRC_PULSE)
        ets_mode = MODE_PULSE;
      else if (src == `ETS_SRC_STANDARD)
        ets_mode = (frames == {{(FRAME_WIDTH-1){1'b0}}, 1'b1}) ? MODE_SINGLE : MODE_STREAM;
      else
        ets_mode = MODE_SOFT;
    end
  endfunction

  assign armCmd = regWrite && (regAddr == `ETS_ADDR_CTRL) && regWrData[`ETS_CTRL_ARM];
  assign captureCmd = regWrite && (regAddr == `ETS_ADDR_CTRL) && regWrData[`ETS_CTRL_CAPTURE];
  assign haltCmd = regWrite && (regAddr == `ETS_ADDR_CTRL) && regWrData[`ETS_CTRL_HALT];
  assign modeSel = ets_mode(triggerSourceSelect_reg, frames_reg);
  assign abortAll = haltCmd;

  // ****************************************
  // Trigger synchroniser and edge detect
  // ****************************************
  // Two flops, then a third stage for edges
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
      trigPrev_reg <= 1'b0;
    end else begin
      syncA_reg <= triggerIn;
      syncB_reg <= syncA_reg;
      trigPrev_reg <= syncB_reg;
    end
  end

  // Active level follows polarity: 1 means rising edge / active high
  assign trigActive = triggerEdgeSelect_reg ? syncB_reg : ~syncB_reg;
  assign trigPrevActive = triggerEdgeSelect_reg ? trigPrev_reg : ~trigPrev_reg;
  assign trigStart = trigActive && !trigPrevActive;
  assign trigStop = !trigActive && trigPrevActive;

  // ****************************************
  // Configuration registers
  // ****************************************
  // Host writes; halt clears the armed state in the sequencer below
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      triggerSourceSelect_reg <= `ETS_SRC_NONE;
      triggerEdgeSelect_reg <= 1'b0;
      frames_reg <= `ETS_RST_FRAMES;
      expose_reg <= `ETS_RST_EXPOSE;
      interval_reg <= `ETS_RST_INTERVAL;
      readout_reg <= `ETS_RST_READOUT;
    end else if (regWrite) begin
      case (regAddr)
        `ETS_ADDR_CTRL: begin
          triggerSourceSelect_reg <= regWrData[`ETS_CTRL_SRC_HI:`ETS_CTRL_SRC_LO];
          triggerEdgeSelect_reg <= regWrData[`ETS_CTRL_EDGE];
        end
        `ETS_ADDR_FRAMES: frames_reg <= regWrData[FRAME_WIDTH-1:0];
        `ETS_ADDR_EXPOSE: expose_reg <= regWrData[TIME_WIDTH-1:0];
        `ETS_ADDR_INTERVAL: interval_reg <= regWrData[TIME_WIDTH-1:0];
        `ETS_ADDR_READOUT: readout_reg <= regWrData[TIME_WIDTH-1:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Timers
  // ****************************************
  ets_count_timer #(.WIDTH(TIME_WIDTH)) expTimer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(expLoad),
    .loadValue(expose_reg),
    .abort(abortAll),
    .busy(),
    .done(expTimerDone)
  );

  ets_count_timer #(.WIDTH(TIME_WIDTH)) readTimer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(readLoad),
    .loadValue(readout_reg),
    .abort(abortAll),
    .busy(),
    .done(readTimerDone)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  // Timer loads for the next state
  always @* begin
    expLoad = 1'b0;
    readLoad = 1'b0;
    case (state_reg)
      ST_IDLE: expLoad = captureCmd && (modeSel == MODE_SOFT);
      ST_ARMED: expLoad = trigStart && (mode_reg != MODE_PULSE);
      ST_EXPOSE: readLoad = (mode_reg == MODE_PULSE) ? trigStop : expTimerDone;
      // Next software frame must reload the exposure timer or it would stall
      ST_READ: expLoad = readTimerDone && (mode_reg == MODE_SOFT) &&
        (frameCount_reg > {{(FRAME_WIDTH-1){1'b0}}, 1'b1});
      ST_WAIT: expLoad = (intervalCount_reg <= {{(TIME_WIDTH-1){1'b0}}, 1'b1});
      default: expLoad = 1'b0;
    endcase
  end

  // Main state, indicator and counters
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      mode_reg <= MODE_SOFT;
      frameCount_reg <= {FRAME_WIDTH{1'b0}};
      intervalCount_reg <= {TIME_WIDTH{1'b0}};
      exposureActive <= 1'b0;
      readoutActive <= 1'b0;
      frameDone <= 1'b0;
    end else begin
      frameDone <= 1'b0;
      if (haltCmd) begin
        state_reg <= ST_IDLE;
        exposureActive <= 1'b0;
        readoutActive <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (captureCmd && modeSel == MODE_SOFT) begin
              mode_reg <= MODE_SOFT;
              frameCount_reg <= frames_reg;
              state_reg <= ST_EXPOSE;
              exposureActive <= 1'b1;
            end else if (armCmd && modeSel != MODE_SOFT) begin
              mode_reg <= modeSel;
              state_reg <= ST_ARMED;
            end
          end
          ST_ARMED: begin
            if (trigStart) begin
              state_reg <= ST_EXPOSE;
              exposureActive <= 1'b1;
              intervalCount_reg <= interval_reg;
            end
          end
          ST_EXPOSE: begin
            if (intervalCount_reg != {TIME_WIDTH{1'b0}})
              intervalCount_reg <= intervalCount_reg - {{(TIME_WIDTH-1){1'b0}}, 1'b1};
            if (readLoad) begin
              state_reg <= ST_READ;
              exposureActive <= 1'b0;
              readoutActive <= 1'b1;
            end
          end
          ST_READ: begin
            if (intervalCount_reg != {TIME_WIDTH{1'b0}})
              intervalCount_reg <= intervalCount_reg - {{(TIME_WIDTH-1){1'b0}}, 1'b1};
            if (readTimerDone) begin
              readoutActive <= 1'b0;
              frameDone <= 1'b1;
              if (mode_reg == MODE_STREAM) begin
                state_reg <= ST_WAIT;
              end else if (mode_reg == MODE_SOFT) begin
                if (frameCount_reg > {{(FRAME_WIDTH-1){1'b0}}, 1'b1}) begin
                  frameCount_reg <= frameCount_reg - {{(FRAME_WIDTH-1){1'b0}}, 1'b1};
                  state_reg <= ST_EXPOSE;
                  exposureActive <= 1'b1;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                state_reg <= ST_ARMED;
              end
            end
          end
          ST_WAIT: begin
            if (expLoad) begin
              state_reg <= ST_EXPOSE;
              exposureActive <= 1'b1;
              intervalCount_reg <= interval_reg;
            end else begin
              intervalCount_reg <= intervalCount_reg - {{(TIME_WIDTH-1){1'b0}}, 1'b1};
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Read data registered, valid the cycle after the strobe
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 32'h0000_0000;
    end else if (regRead) begin
      case (regAddr)
        `ETS_ADDR_CTRL: regRdData <= {29'h0000_0000, triggerEdgeSelect_reg, triggerSourceSelect_reg};
        `ETS_ADDR_FRAMES: regRdData <= {{(32-FRAME_WIDTH){1'b0}}, frames_reg};
        `ETS_ADDR_EXPOSE: regRdData <= expose_reg;
        `ETS_ADDR_INTERVAL: regRdData <= interval_reg;
        `ETS_ADDR_READOUT: regRdData <= readout_reg;
        `ETS_ADDR_STATUS: regRdData <= {23'h00_0000, mode_reg, readoutActive, exposureActive, state_reg};
        `ETS_ADDR_COUNT: regRdData <= {{(32-FRAME_WIDTH){1'b0}}, frameCount_reg};
        default: regRdData <= 32'h0000_0000;
      endcase
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

endmodule // ets_exposure_sequencer

/* File: bench/ets_trig_model.sv */
/* Trigger source model: drives the trigger pin with one active pulse.
   Assumes bench commands arrive on the rising clock edge. */
`timescale 1ns/10ps
module ets_trig_model (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Command from bench
  input wire fire,
  input wire idleLevel,
  input wire [7:0] width,
  // Trigger pin
  output wire triggerIn
);
  reg [7:0] cntReg;
  // Pulse length counter; the source owns the pulse width
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cntReg <= 8'h00;
    end else if (fire) begin
      cntReg <= width;
    end else if (cntReg != 8'h00) begin
      cntReg <= cntReg - 8'h01;
    end
  end
  // Active level is the inverse of the idle level
  assign triggerIn = (cntReg != 8'h00) ? ~idleLevel : idleLevel;
endmodule // ets_trig_model

/* File: bench/ets_seq_checker.sv */
/* Port checker for the exposure sequencer.
   Assumes timing registers are rewritten only while idle. */
`timescale 1ns/10ps
`include "ets_defines.vh"
module ets_seq_checker (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Register port
  input wire [3:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [31:0] regRdData,
  // Trigger and equipment
  input wire triggerIn,
  input wire exposureActive,
  input wire readoutActive,
  input wire frameDone
);
  reg [1:0] srcReg;
  reg edgeReg;
  reg [31:0] expLenReg;
  reg [31:0] rdLenReg;
  reg [31:0] expCntReg;
  reg [31:0] rdCntReg;
  wire isPulse = srcReg == `ETS_SRC_PULSE;
  // Shadow of host settings and phase lengths
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      srcReg <= `ETS_SRC_NONE;
      edgeReg <= 1'b0;
      expLenReg <= `ETS_RST_EXPOSE;
      rdLenReg <= `ETS_RST_READOUT;
      expCntReg <= 32'h0000_0000;
      rdCntReg <= 32'h0000_0000;
    end else begin
      if (regWrite && regAddr == `ETS_ADDR_CTRL) begin
        srcReg <= regWrData[1:0];
        edgeReg <= regWrData[`ETS_CTRL_EDGE];
      end
      if (regWrite && regAddr == `ETS_ADDR_EXPOSE) expLenReg <= regWrData;
      if (regWrite && regAddr == `ETS_ADDR_READOUT) rdLenReg <= regWrData;
      expCntReg <= exposureActive ? expCntReg + 32'h0000_0001 : 32'h0000_0000;
      rdCntReg <= readoutActive ? rdCntReg + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_PHASE_EXCL: assert property (!(exposureActive && readoutActive))
    else $error("exposure and readout overlap");
  AST_DONE_PULSE: assert property (frameDone |=> !frameDone)
    else $error("frame done longer than one cycle");
  AST_DONE_AFTER_READ: assert property (frameDone |-> $past(readoutActive))
    else $error("frame done without readout");
  AST_READ_AFTER_EXP: assert property ($rose(readoutActive) |-> $past(exposureActive))
    else $error("readout not right after exposure");
  AST_READ_LEN: assert property (frameDone |-> rdCntReg == rdLenReg || rdCntReg == rdLenReg + 1)
    else $error("readout length wrong");
  AST_EXP_LEN: assert property ($rose(readoutActive) && !isPulse |->
    expCntReg == expLenReg || expCntReg == expLenReg + 1)
    else $error("timed exposure length wrong");
  AST_PULSE_START: assert property ($rose(exposureActive) && isPulse |-> $past(triggerIn, 2) == edgeReg)
    else $error("pulse exposure began without active trigger");
  AST_PULSE_END: assert property ((isPulse && triggerIn != edgeReg) [*6] |-> !exposureActive)
    else $error("pulse exposure outlived trigger");
  AST_HALT: assert property (regWrite && regAddr == `ETS_ADDR_CTRL && regWrData[`ETS_CTRL_HALT] |->
    ##3 (!exposureActive && !readoutActive))
    else $error("halt did not stop acquisition");
endmodule // ets_seq_checker
bind ets_exposure_sequencer ets_seq_checker chk (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .triggerIn(triggerIn), .exposureActive(exposureActive), .readoutActive(readoutActive), .frameDone(frameDone));

/* File: bench/tb_top.sv */
/* Self-checking bench for the exposure sequencer.
   Assumes the trigger model and checker are compiled first. */
`timescale 1ns/10ps
`include "ets_defines.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %0h want %0h", $time, g, e); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0000_0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic fire = 1'b0;
  logic idleLevel = 1'b1;
  logic [7:0] width = 8'h00;
  wire [31:0] regRdData;
  wire triggerIn, exposureActive, readoutActive, frameDone;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  int t0;
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  ets_exposure_sequencer dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .triggerIn(triggerIn),
    .exposureActive(exposureActive), .readoutActive(readoutActive), .frameDone(frameDone));
  ets_trig_model trig (.clk_sys(clk_sys), .rst_n(rst_n), .fire(fire), .idleLevel(idleLevel),
    .width(width), .triggerIn(triggerIn));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input [3:0] a, input [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input [3:0] a, input [31:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    `CHK(regRdData, e)
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? exposureActive : (s == 1 ? readoutActive : frameDone);
  endfunction
  // Bounded wait for an output level
  task automatic wait_for(input int s, input logic v, input int maxc);
    for (int i = 0; i < maxc && pick(s) !== v; i++) begin
      @(posedge clk_sys);
      #1;
    end
    total_checks++;
    if (pick(s) !== v) begin
      n_fail++;
      $display("mismatch at %0t: wait on output %0d ran out", $time, s);
      stop_test();
    end
  endtask
  task automatic count_rises(input int s, input int ncyc, output int k);
    logic prev;
    k = 0;
    prev = pick(s);
    for (int i = 0; i < ncyc; i++) begin
      @(posedge clk_sys);
      #1;
      if (pick(s) === 1'b1 && prev !== 1'b1) k++;
      prev = pick(s);
    end
  endtask
  task automatic fire_trig(input [7:0] w);
    @(posedge clk_sys);
    width <= w;
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    #1;
  endtask
  function automatic [31:0] ctl(input [1:0] s, input e, input [31:0] x);
    ctl = x | {29'h0000_0000, e, s};
  endfunction
  // Expose 5, readout 8, then arm
  task automatic setup(input [1:0] s, input e, input [31:0] f, input [31:0] iv);
    idleLevel <= !e;
    wr(`ETS_ADDR_FRAMES, f);
    wr(`ETS_ADDR_EXPOSE, 32'h0000_0005);
    wr(`ETS_ADDR_READOUT, 32'h0000_0008);
    wr(`ETS_ADDR_INTERVAL, iv);
    wr(`ETS_ADDR_CTRL, ctl(s, e, 32'h0000_0000));
    wr(`ETS_ADDR_CTRL, ctl(s, e, 32'h0000_0008));
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rd_chk(`ETS_ADDR_FRAMES, {16'h0000, `ETS_RST_FRAMES});
    rd_chk(`ETS_ADDR_EXPOSE, `ETS_RST_EXPOSE);
    rd_chk(`ETS_ADDR_INTERVAL, `ETS_RST_INTERVAL);
    rd_chk(`ETS_ADDR_READOUT, `ETS_RST_READOUT);
    // Idle state, software mode after reset
    rd_chk(`ETS_ADDR_STATUS, 32'h0000_0181);
    wr(4'hF, 32'hFFFF_FFFF);
    rd_chk(4'hF, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic t_single(input logic e);
    setup(`ETS_SRC_STANDARD, e, 32'h0000_0001, 32'h0000_0028);
    fire_trig(8'h03);
    wait_for(0, 1'b1, 10);
    wait_for(1, 1'b1, 12);
    fire_trig(8'h02);
    wait_for(2, 1'b1, 12);
    count_rises(0, 20, n);
    `CHK(n, 0)
    fire_trig(8'h03);
    wait_for(0, 1'b1, 10);
    wait_for(2, 1'b1, 25);
    wr(`ETS_ADDR_CTRL, ctl(`ETS_SRC_STANDARD, e, 32'h0000_0020));
    $display("test single %0d done", e);
  endtask
  task automatic t_stream(input [31:0] f);
    setup(`ETS_SRC_STANDARD, 1'b0, f, 32'h0000_001E);
    fire_trig(8'h03);
    wait_for(0, 1'b1, 10);
    t0 = cyc;
    wait_for(1, 1'b1, 12);
    wait_for(1, 1'b0, 15);
    fire_trig(8'h03);
    wait_for(0, 1'b1, 30);
    `CHK(cyc - t0, 30)
    wr(`ETS_ADDR_CTRL, ctl(`ETS_SRC_STANDARD, 1'b0, 32'h0000_0020));
    count_rises(0, 40, n);
    `CHK(n, 0)
    $display("test stream %0d done", f);
  endtask
  task automatic t_pulse();
    setup(`ETS_SRC_PULSE, 1'b1, 32'h0000_0001, 32'h0000_001E);
    fire_trig(8'h0C);
    wait_for(0, 1'b1, 10);
    t0 = cyc;
    wait_for(0, 1'b0, 20);
    `CHK(cyc - t0, 12)
    fire_trig(8'h02);
    wait_for(2, 1'b1, 12);
    count_rises(0, 20, n);
    `CHK(n, 0)
    wr(`ETS_ADDR_CTRL, ctl(`ETS_SRC_PULSE, 1'b1, 32'h0000_0020));
    $display("test pulse done");
  endtask
  task automatic t_soft();
    idleLevel <= 1'b1;
    wr(`ETS_ADDR_FRAMES, 32'h0000_0003);
    // Capture decodes the stored source, so select none first
    wr(`ETS_ADDR_CTRL, ctl(`ETS_SRC_NONE, 1'b0, 32'h0000_0000));
    wr(`ETS_ADDR_CTRL, ctl(`ETS_SRC_NONE, 1'b0, 32'h0000_0010));
    fire_trig(8'h04);
    count_rises(2, 150, n);
    `CHK(n, 3)
    $display("test soft done");
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_single(1'b0);
    t_single(1'b1);
    t_stream(32'h0000_0000);
    t_stream(32'h0000_0003);
    t_pulse();
    t_soft();
    stop_test();
  end
endmodule // tb_top
